// ==== src/ddscc_consts.vh ====
// Constants shared by the dual channel coordinator
`ifndef DDSCC_CONSTS_VH
`define DDSCC_CONSTS_VH
`define DDSCC_WORD_W 52
`define DDSCC_SYNTH_CLK_MHZ 2500
`define DDSCC_SAMPLE_W 16
`define DDSCC_AMP_W 16
`define DDSCC_PHASE_W 16
`define DDSCC_PAR_FREQ 2'h0
`define DDSCC_PAR_AMP 2'h1
`define DDSCC_PAR_PHASE 2'h2
`define DDSCC_PAR_OTHER 2'h3
`define DDSCC_CPL_FREQ 0
`define DDSCC_CPL_AMP 1
`define DDSCC_CPL_PHASE 2
`define DDSCC_RATIO_FRAC 8
`endif

// ==== src/ddscc_ratio_round.v ====
// Rounds a fixed point ratio to an integer tuning word
`timescale 1ns/100ps
`default_nettype none
module ddscc_ratio_round #(
  parameter WORD_W = 52,
  parameter FRAC_W = 16
) (
  // Ratio with FRAC_W fraction bits
  input wire [WORD_W+FRAC_W-1:0] ratio_fx,
  // Rounded word
  output wire [WORD_W-1:0] word_out
);
  wire [WORD_W+FRAC_W-1:0] half;
  wire [WORD_W+FRAC_W-1:0] sum;
  assign half = {{WORD_W{1'b0}}, 1'b1, {(FRAC_W-1){1'b0}}};
  assign sum = ratio_fx + half;
  // Round half up, nearest integer
  assign word_out = sum[WORD_W+FRAC_W-1:FRAC_W];
endmodule
`default_nettype wire

// ==== src/ddscc_sat_add.v ====
// Saturating adder for the summed channels
`timescale 1ns/100ps
`default_nettype none
module ddscc_sat_add #(
  parameter W = 16
) (
  // Signed samples
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  // Clamped sum
  output wire [W-1:0] sum
);
  wire [W:0] full;
  assign full = {a[W-1], a} + {b[W-1], b};
  // Clamp rather than wrap on overflow
  assign sum = (full[W] != full[W-1]) ?
    (full[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}}) :
    full[W-1:0];
endmodule
`default_nettype wire

// ==== src/ddscc_top.v ====
// Dual channel DDS coordinator: tuning, phase lock, propagation, combine
// Summary of operation
// - Output frequency is clock times word over two to the 52.
// - A frequency write without a locked multiple takes the requested ratio rounded to nearest.
// - Independent mode: with coupling off, one channel's writes never touch the other.
// - Locked mode: time parameter writes reset both accumulators together.
// - Locked mode: integer-multiple higher word equals multiple times lower.
// - Equal-phase command sets both accumulator phases to one value.
// - Each port selects its own channel or the saturated sum.
// - Tracking copies every channel_a write into both channels.
// - Tracking forces locked mode and rejects channel_b writes.
// - Coupling converts a change on either channel and applies it to the other.
// - Frequency, amplitude, phase coupling each ratio or offset.
// - Copy transfers all parameters once; later writes stay separate.
`timescale 1ns/100ps
`default_nettype none
`include "ddscc_consts.vh"
module ddscc_top #(
  parameter WORD_W = `DDSCC_WORD_W,
  parameter FRAC_W = 16,
  parameter SAMPLE_W = `DDSCC_SAMPLE_W,
  parameter AMP_W = `DDSCC_AMP_W,
  parameter PH_W = `DDSCC_PHASE_W
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Parameter write port
  input wire wr_valid,
  input wire wr_chan,
  input wire [1:0] wr_param,
  input wire [WORD_W+FRAC_W-1:0] wr_ratio,
  input wire [AMP_W-1:0] wr_amp,
  input wire [PH_W-1:0] wr_phase,
  input wire [WORD_W-1:0] wr_multiple,
  output wire wr_rejected,
  // Mode controls
  input wire locked_mode,
  input wire track_en,
  input wire [2:0] couple_en,
  input wire [2:0] couple_offset,
  input wire [WORD_W-1:0] couple_freq_k,
  input wire [AMP_W-1:0] couple_amp_k,
  input wire [PH_W-1:0] couple_phase_k,
  // Commands
  input wire equal_phase_cmd,
  input wire copy_cmd,
  input wire copy_dir_b_to_a,
  // Output selection
  input wire port1_sum_sel,
  input wire port2_sum_sel,
  // Channel samples from the waveform engines
  input wire [SAMPLE_W-1:0] channel_a_sample,
  input wire [SAMPLE_W-1:0] channel_b_sample,
  // Channel state
  output reg [WORD_W-1:0] phase_increment_word_a_q,
  output reg [WORD_W-1:0] phase_increment_word_b_q,
  output reg [AMP_W-1:0] amp_a_q,
  output reg [AMP_W-1:0] amp_b_q,
  output reg [PH_W-1:0] phase_off_a_q,
  output reg [PH_W-1:0] phase_off_b_q,
  output reg [WORD_W-1:0] acc_a_q,
  output reg [WORD_W-1:0] acc_b_q,
  output wire locked_eff,
  // Output ports
  output reg [SAMPLE_W-1:0] port1_q,
  output reg [SAMPLE_W-1:0] port2_q
);
  wire [WORD_W-1:0] rounded;
  wire [SAMPLE_W-1:0] summed_channels;
  wire wr_ok;
  wire wr_a;
  wire wr_b;
  wire time_wr;
  wire acc_reset;
  wire [2*WORD_W-1:0] mult_full;
  wire [WORD_W-1:0] mult_word;
  wire [2*WORD_W-1:0] cpl_f_full;
  wire [WORD_W-1:0] cpl_freq;
  wire [2*AMP_W-1:0] cpl_a_full;
  wire [AMP_W-1:0] cpl_amp;
  wire [2*PH_W-1:0] cpl_p_full;
  wire [PH_W-1:0] cpl_phase;
  wire [WORD_W-1:0] new_freq;
  wire [WORD_W+`DDSCC_RATIO_FRAC-1:0] rev_f_full;
  wire [WORD_W-1:0] cpl_freq_rev;
  wire [AMP_W+`DDSCC_RATIO_FRAC-1:0] rev_a_full;
  wire [AMP_W-1:0] cpl_amp_rev;
  wire [PH_W+`DDSCC_RATIO_FRAC-1:0] rev_p_full;
  wire [PH_W-1:0] cpl_phase_rev;
  reg [WORD_W-1:0] fa_d;
  reg [WORD_W-1:0] fb_d;
  reg [AMP_W-1:0] aa_d;
  reg [AMP_W-1:0] ab_d;
  reg [PH_W-1:0] pa_d;
  reg [PH_W-1:0] pb_d;

  ddscc_ratio_round #(
    .WORD_W(WORD_W),
    .FRAC_W(FRAC_W)
  ) u_round (
    .ratio_fx(wr_ratio),
    .word_out(rounded)
  );

  ddscc_sat_add #(
    .W(SAMPLE_W)
  ) u_sum (
    .a(channel_a_sample),
    .b(channel_b_sample),
    .sum(summed_channels)
  );

  assign locked_eff = locked_mode | track_en;
  assign wr_rejected = wr_valid & track_en & wr_chan;
  assign wr_ok = wr_valid & ~wr_rejected;
  assign wr_a = wr_ok & ~wr_chan;
  assign wr_b = wr_ok & wr_chan;
  // Frequency, phase and other timing writes count as time parameters
  assign time_wr = wr_ok & (wr_param != `DDSCC_PAR_AMP);
  assign acc_reset = locked_eff & time_wr;

  // Locked multiple: the other channel's current word times the integer
  assign mult_full = (wr_chan ? phase_increment_word_a_q :
    phase_increment_word_b_q) * wr_multiple;
  assign mult_word = mult_full[WORD_W-1:0];

  // New word for a frequency write, whichever channel it targets
  assign new_freq = (locked_eff && wr_multiple != {WORD_W{1'b0}}) ?
    mult_word : rounded;

  // Coupling relationships, channel_a is reference; ratio k has 8 frac bits.
  // Built from the written value, so propagation never loops through fa_d.
  assign cpl_f_full = new_freq * couple_freq_k;
  assign cpl_freq = couple_offset[`DDSCC_CPL_FREQ] ?
    new_freq + couple_freq_k :
    cpl_f_full[WORD_W+`DDSCC_RATIO_FRAC-1:`DDSCC_RATIO_FRAC];
  assign cpl_a_full = wr_amp * couple_amp_k;
  assign cpl_amp = couple_offset[`DDSCC_CPL_AMP] ?
    wr_amp + couple_amp_k :
    cpl_a_full[AMP_W+`DDSCC_RATIO_FRAC-1:`DDSCC_RATIO_FRAC];
  assign cpl_p_full = wr_phase * couple_phase_k;
  assign cpl_phase = couple_offset[`DDSCC_CPL_PHASE] ?
    wr_phase + couple_phase_k :
    cpl_p_full[PH_W+`DDSCC_RATIO_FRAC-1:`DDSCC_RATIO_FRAC];

  // Reverse relations for channel_b writes. The ratio path needs a divider,
  // which costs area; a zero ratio has no inverse and leaves channel_a alone.
  assign rev_f_full = {new_freq, {`DDSCC_RATIO_FRAC{1'b0}}} / couple_freq_k;
  assign cpl_freq_rev = couple_offset[`DDSCC_CPL_FREQ] ?
    new_freq - couple_freq_k :
    (couple_freq_k == {WORD_W{1'b0}}) ? phase_increment_word_a_q :
    rev_f_full[WORD_W-1:0];
  assign rev_a_full = {wr_amp, {`DDSCC_RATIO_FRAC{1'b0}}} / couple_amp_k;
  assign cpl_amp_rev = couple_offset[`DDSCC_CPL_AMP] ?
    wr_amp - couple_amp_k :
    (couple_amp_k == {AMP_W{1'b0}}) ? amp_a_q :
    rev_a_full[AMP_W-1:0];
  assign rev_p_full = {wr_phase, {`DDSCC_RATIO_FRAC{1'b0}}} / couple_phase_k;
  assign cpl_phase_rev = couple_offset[`DDSCC_CPL_PHASE] ?
    wr_phase - couple_phase_k :
    (couple_phase_k == {PH_W{1'b0}}) ? phase_off_a_q :
    rev_p_full[PH_W-1:0];

  always @* begin
    fa_d = phase_increment_word_a_q;
    fb_d = phase_increment_word_b_q;
    aa_d = amp_a_q;
    ab_d = amp_b_q;
    pa_d = phase_off_a_q;
    pb_d = phase_off_b_q;
    // Own channel write; the other channel is untouched unless propagated
    if (wr_a) begin
      case (wr_param)
        `DDSCC_PAR_FREQ: begin
          fa_d = new_freq;
        end
        `DDSCC_PAR_AMP: begin
          aa_d = wr_amp;
        end
        `DDSCC_PAR_PHASE: begin
          pa_d = wr_phase;
        end
        default: begin
        end
      endcase
    end
    if (wr_b) begin
      case (wr_param)
        `DDSCC_PAR_FREQ: begin
          fb_d = new_freq;
        end
        `DDSCC_PAR_AMP: begin
          ab_d = wr_amp;
        end
        `DDSCC_PAR_PHASE: begin
          pb_d = wr_phase;
        end
        default: begin
        end
      endcase
    end
    if (track_en) begin
      // Both channels stay identical
      fb_d = fa_d;
      ab_d = aa_d;
      pb_d = pa_d;
    end else if (wr_a) begin
      if (couple_en[`DDSCC_CPL_FREQ] && wr_param == `DDSCC_PAR_FREQ) begin
        fb_d = cpl_freq;
      end
      if (couple_en[`DDSCC_CPL_AMP] && wr_param == `DDSCC_PAR_AMP) begin
        ab_d = cpl_amp;
      end
      if (couple_en[`DDSCC_CPL_PHASE] && wr_param == `DDSCC_PAR_PHASE) begin
        pb_d = cpl_phase;
      end
    end else if (wr_b) begin
      // A coupled change on channel_b is mapped back onto channel_a
      if (couple_en[`DDSCC_CPL_FREQ] && wr_param == `DDSCC_PAR_FREQ) begin
        fa_d = cpl_freq_rev;
      end
      if (couple_en[`DDSCC_CPL_AMP] && wr_param == `DDSCC_PAR_AMP) begin
        aa_d = cpl_amp_rev;
      end
      if (couple_en[`DDSCC_CPL_PHASE] && wr_param == `DDSCC_PAR_PHASE) begin
        pa_d = cpl_phase_rev;
      end
    end
    // One-shot copy; it wins over a same-cycle write
    if (copy_cmd && !track_en) begin
      if (copy_dir_b_to_a) begin
        fa_d = phase_increment_word_b_q;
        aa_d = amp_b_q;
        pa_d = phase_off_b_q;
      end else begin
        fb_d = phase_increment_word_a_q;
        ab_d = amp_a_q;
        pb_d = phase_off_a_q;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_increment_word_a_q <= {WORD_W{1'b0}};
      phase_increment_word_b_q <= {WORD_W{1'b0}};
      amp_a_q <= {AMP_W{1'b0}};
      amp_b_q <= {AMP_W{1'b0}};
      phase_off_a_q <= {PH_W{1'b0}};
      phase_off_b_q <= {PH_W{1'b0}};
    end else begin
      phase_increment_word_a_q <= fa_d;
      phase_increment_word_b_q <= fb_d;
      amp_a_q <= aa_d;
      amp_b_q <= ab_d;
      phase_off_a_q <= pa_d;
      phase_off_b_q <= pb_d;
    end
  end

  // Accumulators; this clock stands in for the synthesis clock
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_a_q <= {WORD_W{1'b0}};
      acc_b_q <= {WORD_W{1'b0}};
    end else if (acc_reset || equal_phase_cmd) begin
      // Both restart together so the outputs align
      acc_a_q <= {WORD_W{1'b0}};
      acc_b_q <= {WORD_W{1'b0}};
    end else begin
      // Step size sets f = clock * word / 2^WORD_W
      acc_a_q <= acc_a_q + phase_increment_word_a_q;
      acc_b_q <= acc_b_q + phase_increment_word_b_q;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port1_q <= {SAMPLE_W{1'b0}};
      port2_q <= {SAMPLE_W{1'b0}};
    end else begin
      port1_q <= port1_sum_sel ? summed_channels : channel_a_sample;
      port2_q <= port2_sum_sel ? summed_channels : channel_b_sample;
    end
  end
endmodule
`default_nettype wire

// ==== verif/ddscc_chk.sv ====
// Concurrent checks on the coordinator's top-level ports
`timescale 1ns/100ps
`default_nettype none
module ddscc_chk #(
  parameter W = 52,
  parameter S = 16,
  parameter A = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Writes, modes and commands
  input wire logic wr_valid, wr_chan, wr_rejected, locked_mode,
  input wire logic track_en, locked_eff, equal_phase_cmd, copy_cmd,
  input wire logic [1:0] wr_param,
  input wire logic [2:0] couple_en,
  // Channel state
  input wire logic [W-1:0] phase_increment_word_a_q,
  input wire logic [W-1:0] phase_increment_word_b_q,
  input wire logic [W-1:0] acc_a_q,
  input wire logic [W-1:0] acc_b_q,
  input wire logic [A-1:0] amp_a_q,
  input wire logic [A-1:0] amp_b_q,
  // Samples and ports
  input wire logic port1_sum_sel, port2_sum_sel,
  input wire logic [S-1:0] channel_a_sample, channel_b_sample,
  input wire logic [S-1:0] port1_q, port2_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rej;
    wr_rejected == (wr_valid && track_en && wr_chan);
  endproperty
  a_rej: assert property (p_rej) else $error("bad reject");
  property p_lock;
    locked_eff == (locked_mode || track_en);
  endproperty
  a_lock: assert property (p_lock) else $error("bad lock");
  property p_indep;
    !locked_eff && wr_valid && !wr_chan && couple_en == 3'h0 && !copy_cmd
      |=> $stable(phase_increment_word_b_q) && $stable(amp_b_q);
  endproperty
  a_indep: assert property (p_indep) else $error("b disturbed");
  property p_rst;
    locked_eff && wr_valid && !wr_rejected && wr_param != 2'h1
      |=> acc_a_q == '0 && acc_b_q == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("no phase reset");
  property p_eq;
    equal_phase_cmd |=> acc_a_q == '0 && acc_b_q == '0;
  endproperty
  a_eq: assert property (p_eq) else $error("phases differ");
  property p_trk;
    track_en && wr_valid && !copy_cmd |=> amp_b_q == amp_a_q &&
      phase_increment_word_b_q == phase_increment_word_a_q;
  endproperty
  a_trk: assert property (p_trk) else $error("not tracked");
  property p_ref;
    wr_rejected && !copy_cmd |=> $stable(amp_a_q) && $stable(amp_b_q);
  endproperty
  a_ref: assert property (p_ref) else $error("refused write landed");
  property p_port;
    !port1_sum_sel && !port2_sum_sel |=> port1_q == $past(channel_a_sample)
      && port2_q == $past(channel_b_sample);
  endproperty
  a_port: assert property (p_port) else $error("port select");
endmodule
bind ddscc_top ddscc_chk #(.W(WORD_W), .S(SAMPLE_W), .A(AMP_W)) u_chk (
  .clk, .rst_n, .wr_valid, .wr_chan, .wr_rejected, .locked_mode, .track_en,
  .locked_eff, .equal_phase_cmd, .copy_cmd, .wr_param, .couple_en,
  .phase_increment_word_a_q, .phase_increment_word_b_q, .acc_a_q, .acc_b_q,
  .amp_a_q, .amp_b_q, .port1_sum_sel, .port2_sum_sel, .channel_a_sample,
  .channel_b_sample, .port1_q, .port2_q);
`default_nettype wire

// ==== verif/testbench.sv ====
// Directed testbench for the dual channel coordinator
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, wr_valid = 1'b0, wr_chan = 1'b0;
  logic locked_mode = 1'b0, track_en = 1'b0, equal_phase_cmd = 1'b0;
  logic copy_cmd = 1'b0, copy_dir_b_to_a = 1'b0, rej;
  logic port1_sum_sel = 1'b0, port2_sum_sel = 1'b0, wr_rejected, locked_eff;
  logic [1:0] wr_param = 2'h0;
  logic [2:0] couple_en = 3'h0, couple_offset = 3'h0;
  logic [67:0] wr_ratio = 68'h0;
  logic [15:0] wr_amp = 16'h0, wr_phase = 16'h0, couple_amp_k = 16'h0;
  logic [15:0] couple_phase_k = 16'h0, channel_a_sample = 16'h0;
  logic [15:0] channel_b_sample = 16'h0, port1_q, port2_q;
  logic [15:0] amp_a_q, amp_b_q, phase_off_a_q, phase_off_b_q;
  logic [51:0] wr_multiple = 52'h0, couple_freq_k = 52'h0, x;
  logic [51:0] phase_increment_word_a_q, phase_increment_word_b_q;
  logic [51:0] acc_a_q, acc_b_q;
  int checks_done = 0, miscompares = 0;
  ddscc_top DUT (.clk, .rst_n, .wr_valid, .wr_chan, .wr_param, .wr_ratio,
    .wr_amp, .wr_phase, .wr_multiple, .wr_rejected, .locked_mode, .track_en,
    .couple_en, .couple_offset, .couple_freq_k, .couple_amp_k,
    .couple_phase_k, .equal_phase_cmd, .copy_cmd, .copy_dir_b_to_a,
    .port1_sum_sel, .port2_sum_sel, .channel_a_sample, .channel_b_sample,
    .phase_increment_word_a_q, .phase_increment_word_b_q, .amp_a_q, .amp_b_q,
    .phase_off_a_q, .phase_off_b_q, .acc_a_q, .acc_b_q, .locked_eff,
    .port1_q, .port2_q);
  always #20 clk = ~clk;
  task automatic chk(input logic [51:0] got, input logic [51:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One-cycle write pulse; rej holds the refusal seen while it was up
  task automatic wr(input logic c, input logic [1:0] p,
                    input logic [67:0] r, input logic [15:0] a);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_chan <= c;
    wr_param <= p;
    wr_ratio <= r;
    wr_amp <= a;
    #1 rej = wr_rejected;
    @(posedge clk);
    wr_valid <= 1'b0;
    #1;
  endtask
  // Three edges: one to load the samples, two more before the registered ports are checked
  task automatic ports(input logic [15:0] a, b, input logic s1, s2,
                       input logic [15:0] e1, e2);
    @(posedge clk);
    channel_a_sample <= a;
    channel_b_sample <= b;
    port1_sum_sel <= s1;
    port2_sum_sel <= s2;
    repeat (2) @(posedge clk);
    #1 chk(port1_q, e1);
    chk(port2_q, e2);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000 miscompares++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(0, 0, {52'd1801439850948, 16'h32b0}, 0);
    chk(phase_increment_word_a_q, 52'd1801439850948);
    wr(1, 0, {52'd18014398509481, 16'hfae1}, 0);
    chk(phase_increment_word_b_q, 52'd18014398509482);
    chk(phase_increment_word_a_q, 52'd1801439850948);
    x = acc_a_q;
    @(posedge clk);
    #1 chk(acc_a_q, x + 52'd1801439850948);
    @(posedge clk) locked_mode <= 1'b1;
    wr_multiple <= 52'd10;
    wr(1, 0, 0, 0);
    chk(phase_increment_word_b_q, 52'd18014398509480);
    chk(acc_a_q | acc_b_q, 0);
    @(posedge clk) locked_mode <= 1'b0;
    wr_multiple <= 52'h0;
    @(posedge clk) equal_phase_cmd <= 1'b1;
    @(posedge clk) equal_phase_cmd <= 1'b0;
    #1 chk(acc_a_q | acc_b_q, 0);
    wr(0, 1, 0, 16'h0123);
    @(posedge clk) copy_cmd <= 1'b1;
    @(posedge clk) copy_cmd <= 1'b0;
    #1 chk(amp_b_q, 16'h0123);
    chk(phase_increment_word_b_q, 52'd1801439850948);
    wr(0, 1, 0, 16'h0456);
    chk(amp_b_q, 16'h0123);
    @(posedge clk) couple_en <= 3'h2;
    couple_amp_k <= 16'h0200;
    wr(0, 1, 0, 16'h0050);
    chk(amp_b_q, 16'h00a0);
    wr(1, 1, 0, 16'h0077);
    chk(amp_a_q, 16'h003b);
    chk(amp_b_q, 16'h0077);
    @(posedge clk) couple_en <= 3'h5;
    couple_offset <= 3'h5;
    couple_freq_k <= 52'd5;
    couple_phase_k <= 16'h0010;
    wr_phase <= 16'h0020;
    wr(0, 0, {52'd1000, 16'h0}, 0);
    chk(phase_increment_word_b_q, 52'd1005);
    wr(1, 0, {52'd2000, 16'h0}, 0);
    chk(phase_increment_word_a_q, 52'd1995);
    wr(0, 2, 0, 0);
    chk(phase_off_b_q, 16'h0030);
    chk(phase_off_a_q, 16'h0020);
    @(posedge clk) couple_en <= 3'h0;
    track_en <= 1'b1;
    wr(0, 1, 0, 16'h0abc);
    chk(amp_b_q, 16'h0abc);
    chk(locked_eff, 1);
    wr(1, 1, 0, 16'h0def);
    chk(rej, 1);
    chk(amp_a_q, 16'h0abc);
    @(posedge clk) track_en <= 1'b0;
    wr(1, 1, 0, 16'h0321);
    @(posedge clk) copy_dir_b_to_a <= 1'b1;
    copy_cmd <= 1'b1;
    @(posedge clk) copy_cmd <= 1'b0;
    #1 chk(amp_a_q, 16'h0321);
    @(posedge clk) locked_mode <= 1'b1;
    wr(0, 3, 0, 0);
    chk(acc_a_q | acc_b_q, 0);
    wr(0, 1, 0, 16'h0111);
    chk(acc_a_q, 52'd3990);
    @(posedge clk) locked_mode <= 1'b0;
    ports(16'h7000, 16'h7000, 1, 0, 16'h7fff, 16'h7000);
    ports(16'h9000, 16'h9000, 0, 1, 16'h9000, 16'h8000);
    ports(16'h0100, 16'h0200, 1, 1, 16'h0300, 16'h0300);
    give_verdict;
  end
endmodule
`default_nettype wire
